// [serial_flash_param_table_rom_test.sv]
// testbench: controller and flash joined by the link, driven over apb
// assumes a short settle count; lane strap matched to each frame's lane except the one invalid-strap frame
`timescale 1ns/1ps
module serial_flash_param_table_rom_test;
  logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [1:0]  lane_mode;
  logic        deep_pd, write_enable_latch;
  logic [7:0]  reads;
  int          errors, comparisons, k;
  logic [7:0]  tbl [16] = '{8'h00, 8'h36, 8'h00, 8'h27, 8'hF6, 8'h4F,
                            8'hFF, 8'hFF, 8'hFE, 8'hC7, 8'hFF, 8'hFF,
                            8'hFF, 8'hFF, 8'hFF, 8'hFF};

  sfdp_link_if sfdp_link_if_i ();
  sfdp_host_ctl #(.SETTLE_CYC(20)) sfdp_host_ctl_i (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .lnk(sfdp_link_if_i));
  sfdp_flash_dev sfdp_flash_dev_i (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_lane_mode(lane_mode),
    .lnk(sfdp_link_if_i), .o_deep_pd(deep_pd),
    .o_write_enable_latch(write_enable_latch), .o_param_reads(reads));
  sfdp_link_checker #(.SETTLE_CYC(20)) sfdp_link_checker_i (
    .i_clk_sys(clk_sys), .i_rst(rst), .sclk(sfdp_link_if_i.sclk),
    .cs_n(sfdp_link_if_i.cs_n), .dev_oe(sfdp_link_if_i.dev_oe),
    .host_oe(sfdp_link_if_i.host_oe));

  // ==========================================================
  // clock, watchdog, verdict
  always #50 clk_sys = ~clk_sys;
  initial begin
    repeat (60000) @(posedge clk_sys);
    errors++;
    complete_run();
  end
  task complete_run();
    if (errors == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // ==========================================================
  // compare, apb cycle, link frame
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rdata = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task frame(input logic [1:0] ln, input logic [7:0] op,
             input logic [23:0] a, input logic [7:0] n);
    apb(1'b1, sfdp_pkg::REG_ADDR, {8'h00, a});
    apb(1'b1, sfdp_pkg::REG_CTRL, {8'h00, n, op, 5'h00, ln, 1'b1});
    rdata = 32'h0;
    for (k = 0; k < 400 && rdata[1] !== 1'b1; k++)
      apb(1'b0, sfdp_pkg::REG_STATUS, 32'h0);
    check(32'(rdata[1]), 32'h1);
    apb(1'b1, sfdp_pkg::REG_STATUS, 32'h0000_0002);
    apb(1'b0, sfdp_pkg::REG_DATA, 32'h0);
  endtask
  // last four bytes of a read ending at table index e, newest lowest
  function automatic logic [31:0] exp4(input int e);
    return {tbl[e-3], tbl[e-2], tbl[e-1], tbl[e]};
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    clk_sys = 0; rst = 1; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; lane_mode = 0; errors = 0; comparisons = 0;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    // start before settle is refused; power-on state
    apb(1'b1, sfdp_pkg::REG_CTRL, {16'h0004, sfdp_pkg::OP_READ_PARAM, 8'h01});
    apb(1'b0, sfdp_pkg::REG_STATUS, 32'h0);
    check(32'(rdata[3:2]), 32'h2);
    check(32'(deep_pd), 32'h0);
    check(32'(write_enable_latch), 32'h0);
    apb(1'b1, sfdp_pkg::REG_STATUS, 32'h0000_0008);
    rdata = 32'h0;
    for (k = 0; k < 100 && rdata[2] !== 1'b1; k++)
      apb(1'b0, sfdp_pkg::REG_STATUS, 32'h0);
    check(32'(rdata[2]), 32'h1);
    // unmapped address and invalid lane mode
    apb(1'b0, 12'h010, 32'h0);
    check(32'(rerr), 32'h1);
    check(rdata, 32'h0);
    apb(1'b1, sfdp_pkg::REG_CTRL, {16'h0004, sfdp_pkg::OP_READ_PARAM, 8'h07});
    apb(1'b0, sfdp_pkg::REG_STATUS, 32'h0);
    check(32'(rdata[3]), 32'h1);
    check(32'(reads), 32'h0);
    apb(1'b1, sfdp_pkg::REG_STATUS, 32'h0000_0008);
    // whole table in each valid lane mode
    for (int l = 0; l < 3; l++) begin
      lane_mode <= l[1:0];
      repeat (24) @(posedge clk_sys);
      for (int i = 0; i < 16; i += 4) begin
        frame(l[1:0], sfdp_pkg::OP_READ_PARAM, 24'h60 + 24'(i), 8'h04);
        check(rdata, exp4(i + 3));
      end
    end
    check(32'(reads), 32'd12);
    // invalid lane strap: flash ignores the whole frame
    lane_mode <= 2'h3;
    repeat (24) @(posedge clk_sys);
    frame(2'h0, sfdp_pkg::OP_WREN, 24'h0, 8'h00);
    check(32'(write_enable_latch), 32'h0);
    check(32'(reads), 32'd12);
    // stream longer than the data register
    lane_mode <= 2'h0;
    repeat (24) @(posedge clk_sys);
    frame(2'h0, sfdp_pkg::OP_READ_PARAM, 24'h66, 8'h06);
    check(rdata, exp4(11));
    // latch and power commands
    frame(2'h0, sfdp_pkg::OP_WREN, 24'h0, 8'h00);
    check(32'(write_enable_latch), 32'h1);
    frame(2'h0, sfdp_pkg::OP_WRDI, 24'h0, 8'h00);
    check(32'(write_enable_latch), 32'h0);
    frame(2'h0, sfdp_pkg::OP_DPD, 24'h0, 8'h00);
    check(32'(deep_pd), 32'h1);
    frame(2'h0, sfdp_pkg::OP_WREN, 24'h0, 8'h00);
    check(32'(write_enable_latch), 32'h0);
    frame(2'h0, sfdp_pkg::OP_RDP, 24'h0, 8'h00);
    check(32'(deep_pd), 32'h0);
    complete_run();
  end
endmodule

// [sfdp_flash_dev.sv]
// flash end: parameter table reads, write enable latch, power state
// assumes the link clock runs free and cs_n is high between frames
`timescale 1ns/1ps
module sfdp_flash_dev #(
  parameter int MODE_BITS  = sfdp_pkg::MODE_BITS_DEF,
  parameter int DUMMY_CLKS = sfdp_pkg::DUMMY_CLKS_DEF
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_lane_mode,
  sfdp_link_if.dev        lnk,
  output logic            o_deep_pd,
  output logic            o_write_enable_latch,
  output logic [7:0]      o_param_reads
);

  // ==========================================================
  // types
  typedef enum logic [1:0] {PH_HDR, PH_DUMMY, PH_DATA, PH_IGNORE} phase_t;
  typedef enum logic {PWR_STANDBY, PWR_DEEP} pwr_t;

  // frame flags, one per command seen
  localparam int F_WREN = 0;
  localparam int F_WRDI = 1;
  localparam int F_DPD  = 2;
  localparam int F_RDP  = 3;
  localparam int F_READ = 4;

  localparam logic [11:0] FRAME_BITS = sfdp_pkg::HDR_BITS +
                                       12'(MODE_BITS);
  localparam logic [7:0]  DUMMY_LAST = 8'(DUMMY_CLKS - 1);

  typedef struct packed {
    phase_t      phase;
    logic [7:0]  cnt;
    logic [39:0] sr_in;
    logic [23:0] addr;
    logic [7:0]  sr_out;
    logic [2:0]  bitcnt;
    logic [4:0]  flags;
  } link_t;

  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] doe;
  } drv_t;

  typedef struct packed {
    logic [1:0] mode_s1;
    logic [1:0] mode_s2;
    logic       dpd_s1;
    logic       dpd_s2;
  } lsync_t;

  typedef struct packed {
    pwr_t       pwr;
    logic       write_enable_latch;
    logic [4:0] fs1;
    logic [4:0] fs2;
    logic [4:0] fprev;
    logic [7:0] reads;
  } sys_t;

  link_t  link_q, link_d;
  drv_t   drv_q, drv_d;
  lsync_t ls_q, ls_d;
  sys_t   sys_q, sys_d;

  logic [1:0]  lane;
  logic [7:0]  op_last;
  logic [7:0]  hdr_last;
  logic [2:0]  byte_last;
  logic [2:0]  lane_w;

  // ==========================================================
  // link domain: lane mode and power state brought over
  always_comb begin
    ls_d         = ls_q;
    ls_d.mode_s1 = i_lane_mode;
    ls_d.mode_s2 = ls_q.mode_s1;
    ls_d.dpd_s1  = (sys_q.pwr == PWR_DEEP);
    ls_d.dpd_s2  = ls_q.dpd_s1;
  end

  // plain data synchroniser, settles on the free-running clock
  always_ff @(posedge lnk.sclk) begin
    ls_q <= ls_d;
  end

  // per-mode edge counts
  always_comb begin
    lane      = ls_q.mode_s2;
    op_last   = 8'(sfdp_pkg::lane_edges(sfdp_pkg::OP_BITS, lane)
                   - 12'h001);
    hdr_last  = 8'(sfdp_pkg::lane_edges(FRAME_BITS, lane) - 12'h001);
    byte_last = 3'(sfdp_pkg::lane_edges(12'h008, lane) - 12'h001);
    lane_w    = 3'(sfdp_pkg::lane_edges(12'h004, 2'h2 - lane));
  end

  // ==========================================================
  // link domain: command, address, dummy and data phases
  always_comb begin
    logic [39:0] sr_nxt;
    logic [23:0] a;
    sr_nxt = link_q.sr_in;
    a      = link_q.addr;
    link_d = link_q;
    case (lane)
      sfdp_pkg::LANE_2: sr_nxt = {link_q.sr_in[37:0], lnk.io[1:0]};
      sfdp_pkg::LANE_4: sr_nxt = {link_q.sr_in[35:0], lnk.io};
      default:          sr_nxt = {link_q.sr_in[38:0], lnk.io[0]};
    endcase
    case (link_q.phase)
      PH_HDR: begin
        link_d.sr_in = sr_nxt;
        link_d.cnt   = link_q.cnt + 8'h01;
        if (lane == sfdp_pkg::LANE_BAD) begin
          link_d.phase = PH_IGNORE;
        end else if (link_q.cnt == op_last) begin
          case (sr_nxt[7:0])
            sfdp_pkg::OP_WREN: begin
              link_d.flags[F_WREN] = 1'b1;
              link_d.phase         = PH_IGNORE;
            end
            sfdp_pkg::OP_WRDI: begin
              link_d.flags[F_WRDI] = 1'b1;
              link_d.phase         = PH_IGNORE;
            end
            sfdp_pkg::OP_DPD: begin
              link_d.flags[F_DPD] = 1'b1;
              link_d.phase        = PH_IGNORE;
            end
            sfdp_pkg::OP_RDP: begin
              link_d.flags[F_RDP] = 1'b1;
              link_d.phase        = PH_IGNORE;
            end
            sfdp_pkg::OP_READ_PARAM: begin
              link_d.flags[F_READ] = 1'b1;
            end
            default: begin
              link_d.phase = PH_IGNORE;
            end
          endcase
        end else if (link_q.cnt == hdr_last) begin
          // address sits above any mode bits
          a           = sr_nxt[MODE_BITS +: 24];
          link_d.addr = a;
          link_d.cnt  = 8'h00;
          if (DUMMY_CLKS == 0) begin
            link_d.phase  = PH_DATA;
            link_d.sr_out = sfdp_pkg::param_byte(a);
            link_d.bitcnt = 3'h0;
          end else begin
            link_d.phase = PH_DUMMY;
          end
        end
      end
      PH_DUMMY: begin
        // wait states after address or mode bits
        link_d.cnt = link_q.cnt + 8'h01;
        if (link_q.cnt == DUMMY_LAST) begin
          link_d.phase  = PH_DATA;
          link_d.sr_out = sfdp_pkg::param_byte(link_q.addr);
          link_d.bitcnt = 3'h0;
        end
      end
      PH_DATA: begin
        if (link_q.bitcnt == byte_last) begin
          // next table byte, rising address
          link_d.addr   = link_q.addr + 24'h000001;
          link_d.sr_out = sfdp_pkg::param_byte(link_d.addr);
          link_d.bitcnt = 3'h0;
        end else begin
          link_d.sr_out = link_q.sr_out << lane_w;
          link_d.bitcnt = link_q.bitcnt + 3'h1;
        end
      end
      default: begin
        link_d.phase = PH_IGNORE;
      end
    endcase
  end

  // frame state ends with the frame's own select
  always_ff @(posedge lnk.sclk or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      link_q <= '0;
    end else begin
      link_q <= link_d;
    end
  end

  // ==========================================================
  // link domain: output lanes change on the falling edge
  always_comb begin
    drv_d = '0;
    if (link_q.phase == PH_DATA && !ls_q.dpd_s2) begin
      case (lane)
        sfdp_pkg::LANE_2: begin
          drv_d.dout = {2'h0, link_q.sr_out[7:6]};
          drv_d.doe  = 4'h3;
        end
        sfdp_pkg::LANE_4: begin
          drv_d.dout = link_q.sr_out[7:4];
          drv_d.doe  = 4'hF;
        end
        default: begin
          // single lane answers on lane 1
          drv_d.dout = {2'h0, link_q.sr_out[7], 1'b0};
          drv_d.doe  = 4'h2;
        end
      endcase
    end
  end

  always_ff @(negedge lnk.sclk or posedge lnk.cs_n) begin
    if (lnk.cs_n) begin
      drv_q <= '0;
    end else begin
      drv_q <= drv_d;
    end
  end

  assign lnk.dev_o  = drv_q.dout;
  assign lnk.dev_oe = drv_q.doe;

  // ==========================================================
  // system domain: power state and write enable latch
  always_comb begin
    logic [4:0] ev;
    ev        = sys_q.fs2 & ~sys_q.fprev;
    sys_d     = sys_q;
    sys_d.fs1 = link_q.flags;
    sys_d.fs2 = sys_q.fs1;
    sys_d.fprev = sys_q.fs2;
    if (sys_q.pwr == PWR_DEEP) begin
      // only release wakes a sleeping part
      if (ev[F_RDP]) begin
        sys_d.pwr = PWR_STANDBY;
      end
    end else begin
      if (ev[F_WREN]) begin
        sys_d.write_enable_latch = 1'b1;
      end else if (ev[F_WRDI]) begin
        sys_d.write_enable_latch = 1'b0;
      end
      if (ev[F_DPD]) begin
        sys_d.pwr = PWR_DEEP;
      end
      if (ev[F_READ]) begin
        sys_d.reads = sys_q.reads + 8'h01;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      sys_q     <= '0;
      sys_q.pwr <= PWR_STANDBY;
      sys_q.write_enable_latch <= 1'b0;
    end else begin
      sys_q <= sys_d;
    end
  end

  assign o_deep_pd            = (sys_q.pwr == PWR_DEEP);
  assign o_write_enable_latch = sys_q.write_enable_latch;
  assign o_param_reads        = sys_q.reads;

endmodule

// [sfdp_host_ctl.sv]
// controller end: apb registers drive link frames to the flash
// assumes apb on the system clock; link clock made here by a divider
`timescale 1ns/1ps
module sfdp_host_ctl #(
  parameter int MODE_BITS  = sfdp_pkg::MODE_BITS_DEF,
  parameter int DUMMY_CLKS = sfdp_pkg::DUMMY_CLKS_DEF,
  parameter int SCLK_HALF  = sfdp_pkg::SCLK_HALF_DEF,
  parameter int SETTLE_CYC = sfdp_pkg::SETTLE_CYC
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [11:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  sfdp_link_if.host        lnk
);

  localparam logic [11:0] FRAME_BITS = sfdp_pkg::HDR_BITS +
                                       12'(MODE_BITS);
  localparam logic [15:0] SETTLE_LAST = 16'(SETTLE_CYC - 1);
  localparam logic [7:0]  HALF_LAST   = 8'(SCLK_HALF - 1);

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  lane;
    logic [7:0]  opcode;
    logic [7:0]  nbytes;
    logic [7:0]  modev;
    logic [23:0] addr;
    logic        go;
    logic        busy;
    logic        done;
    logic        refused;
    logic        settled;
    logic [15:0] settle;
    logic [7:0]  div;
    logic        sclk;
    logic        cs_n;
    logic [3:0]  io_o;
    logic [3:0]  io_oe;
    logic [3:0]  s1;
    logic [3:0]  s2;
    logic [11:0] cyc;
    logic [11:0] hdr;
    logic [11:0] dstart;
    logic [11:0] total;
    logic [39:0] sr;
    logic [31:0] rdata;
  } host_t;

  host_t h_q, h_d;

  // ==========================================================
  // registers, link clock and frame engine
  always_comb begin
    logic acc;
    logic wr;
    logic fall;
    logic [11:0] e8;
    acc  = i_psel & i_penable;
    wr   = acc & h_q.pready & i_pwrite;
    fall = 1'b0;
    h_d  = h_q;
    h_d.s1 = lnk.io;
    h_d.s2 = h_q.s1;
    e8   = sfdp_pkg::lane_edges(12'h008, h_q.lane);
    // one wait state, then answer
    h_d.pready  = acc & ~h_q.pready;
    h_d.pslverr = 1'b0;
    if (acc && !h_q.pready) begin
      h_d.prdata = 32'h00000000;
      if (i_paddr == sfdp_pkg::REG_CTRL) begin
        h_d.prdata = {h_q.modev, h_q.nbytes, h_q.opcode, 5'h00,
                      h_q.lane, 1'b0};
      end else if (i_paddr == sfdp_pkg::REG_ADDR) begin
        h_d.prdata = {8'h00, h_q.addr};
      end else if (i_paddr == sfdp_pkg::REG_STATUS) begin
        h_d.prdata = {28'h0000000, h_q.refused, h_q.settled,
                      h_q.done, h_q.busy};
      end else if (i_paddr == sfdp_pkg::REG_DATA) begin
        h_d.prdata = h_q.rdata;
      end else begin
        h_d.pslverr = 1'b1;
      end
    end
    if (wr) begin
      if (i_paddr == sfdp_pkg::REG_CTRL) begin
        h_d.lane   = i_pwdata[2:1];
        h_d.opcode = i_pwdata[15:8];
        h_d.nbytes = i_pwdata[23:16];
        h_d.modev  = i_pwdata[31:24];
        if (i_pwdata[0]) begin
          // refuse bad lane mode, early start or overlap
          if (h_q.busy || h_q.go || !h_q.settled ||
              i_pwdata[2:1] == sfdp_pkg::LANE_BAD) begin
            h_d.refused = 1'b1;
          end else begin
            h_d.go = 1'b1;
          end
        end
      end else if (i_paddr == sfdp_pkg::REG_ADDR) begin
        h_d.addr = i_pwdata[23:0];
      end else if (i_paddr == sfdp_pkg::REG_STATUS) begin
        if (i_pwdata[1]) h_d.done = 1'b0;
        if (i_pwdata[3]) h_d.refused = 1'b0;
      end
    end
    // supply settle delay before any command
    if (!h_q.settled) begin
      h_d.settle = h_q.settle + 16'h0001;
      if (h_q.settle == SETTLE_LAST) h_d.settled = 1'b1;
    end
    // free-running link clock
    if (h_q.div == HALF_LAST) begin
      h_d.div  = 8'h00;
      h_d.sclk = ~h_q.sclk;
      fall     = h_q.sclk;
    end else begin
      h_d.div = h_q.div + 8'h01;
    end
    if (fall) begin
      if (h_q.busy && h_q.cyc > h_q.dstart) begin
        case (h_q.lane)
          sfdp_pkg::LANE_2: h_d.rdata = {h_q.rdata[29:0], h_q.s2[1:0]};
          sfdp_pkg::LANE_4: h_d.rdata = {h_q.rdata[27:0], h_q.s2};
          default:          h_d.rdata = {h_q.rdata[30:0], h_q.s2[1]};
        endcase
      end
      if (h_q.busy && h_q.cyc == h_q.total) begin
        h_d.busy  = 1'b0;
        h_d.done  = 1'b1;
        h_d.cs_n  = 1'b1;
        h_d.io_oe = 4'h0;
      end else if (!h_q.busy && h_q.go) begin
        h_d.go    = 1'b0;
        h_d.busy  = 1'b1;
        h_d.cs_n  = 1'b0;
        h_d.cyc   = 12'h000;
        h_d.rdata = 32'h00000000;
        // mode bits follow the address
        h_d.sr    = {h_q.opcode, h_q.addr, h_q.modev};
        if (h_q.nbytes == 8'h00) begin
          h_d.hdr    = e8;
          h_d.dstart = e8;
        end else begin
          h_d.hdr    = sfdp_pkg::lane_edges(FRAME_BITS, h_q.lane);
          h_d.dstart = h_d.hdr + 12'(DUMMY_CLKS);
        end
        h_d.total = h_d.dstart + {4'h0, h_q.nbytes} * e8;
      end
      if (h_d.busy) begin
        h_d.io_oe = 4'h0;
        if (h_d.cyc < h_d.hdr) begin
          case (h_q.lane)
            sfdp_pkg::LANE_2: begin
              h_d.io_o  = {2'h0, h_d.sr[39:38]};
              h_d.io_oe = 4'h3;
            end
            sfdp_pkg::LANE_4: begin
              h_d.io_o  = h_d.sr[39:36];
              h_d.io_oe = 4'hF;
            end
            default: begin
              h_d.io_o  = {3'h0, h_d.sr[39]};
              h_d.io_oe = 4'h1;
            end
          endcase
          h_d.sr = h_d.sr << sfdp_pkg::lane_edges(12'h004,
                                                  2'h2 - h_q.lane);
        end
        h_d.cyc = h_d.cyc + 12'h001;
      end
    end
  end

  // select held high from reset until the first frame
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      h_q      <= '0;
      h_q.cs_n <= 1'b1;
    end else begin
      h_q <= h_d;
    end
  end

  assign o_prdata    = h_q.prdata;
  assign o_pready    = h_q.pready;
  assign o_pslverr   = h_q.pslverr;
  assign lnk.sclk    = h_q.sclk;
  assign lnk.cs_n    = h_q.cs_n;
  assign lnk.host_o  = h_q.io_o;
  assign lnk.host_oe = h_q.io_oe;

endmodule

// [sfdp_link_checker.sv]
// checker for the flash link: frame shape, lane ownership, select timing
// assumes link signals plus system clock and reset as plain inputs
`timescale 1ns/1ps
module sfdp_link_checker #(
  parameter int SETTLE_CYC = 1000
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic [3:0] dev_oe,
  input  wire logic [3:0] host_oe
);
  // ==========================================================
  // helper: system cycles since reset release, saturating
  int unsigned up_q;
  logic        settled;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) up_q <= 0;
    else if (up_q < SETTLE_CYC) up_q <= up_q + 1;
  end
  assign settled = (up_q >= SETTLE_CYC);

  // ==========================================================
  // system domain
  chk_select_settled: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) !cs_n |-> settled) else $error("select early");
  chk_reset_idle: assert property (@(posedge i_clk_sys)
    i_rst |=> cs_n && !sclk && host_oe == 4'h0) else $error("not idle");
  chk_cs_sclk_low: assert property (@(posedge i_clk_sys)
    disable iff (i_rst) $changed(cs_n) |-> !sclk) else $error("cs edge");

  // ==========================================================
  // link domain
  chk_idle_no_drive: assert property (@(posedge sclk)
    disable iff (i_rst) cs_n |-> dev_oe == 4'h0) else $error("idle drive");
  chk_no_contention: assert property (@(posedge sclk)
    disable iff (cs_n) (dev_oe & host_oe) == 4'h0) else $error("clash");
  chk_lane_set: assert property (@(posedge sclk)
    disable iff (i_rst) dev_oe inside {4'h0, 4'h2, 4'h3, 4'hF})
    else $error("bad lanes");
  chk_dummy_gap: assert property (@(negedge sclk) disable iff (cs_n)
    $fell(|host_oe) |-> (dev_oe == 4'h0) [*8] ##1 (dev_oe != 4'h0))
    else $error("dummy count");
  chk_data_contig: assert property (@(posedge sclk)
    disable iff (cs_n) dev_oe != 4'h0 |=> dev_oe != 4'h0)
    else $error("data gap");

  // main scenarios reached
  cover property (@(negedge sclk) dev_oe == 4'h2);
  cover property (@(negedge sclk) dev_oe == 4'h3);
  cover property (@(negedge sclk) dev_oe == 4'hF);
  cover property (@(posedge i_clk_sys) $fell(cs_n));
endmodule

// [sfdp_link_if.sv]
// serial link between controller and flash: clock, select, four io lanes
// assumes a pull-up on every lane that nobody drives
`timescale 1ns/1ps
interface sfdp_link_if;
  logic       sclk;
  logic       cs_n;
  logic [3:0] dev_o;
  logic [3:0] dev_oe;
  logic [3:0] host_o;
  logic [3:0] host_oe;
  logic [3:0] io;

  // wire level from the two drivers, pulled high when idle
  assign io = (dev_oe & dev_o) | (~dev_oe & host_oe & host_o) |
              (~dev_oe & ~host_oe);

  modport dev  (input sclk, cs_n, io, output dev_o, dev_oe);
  modport host (output sclk, cs_n, host_o, host_oe, input io);
endinterface

// [sfdp_pkg.sv]
// shared constants for the parameter-table flash link and its controller
// assumes both ends agree on lane mode, mode bits and dummy clocks
package sfdp_pkg;

  // ==========================================================
  // command opcodes
  localparam logic [7:0] OP_READ_PARAM = 8'h5A;
  localparam logic [7:0] OP_WREN       = 8'h06;
  localparam logic [7:0] OP_WRDI       = 8'h04;
  localparam logic [7:0] OP_DPD        = 8'hB9;
  localparam logic [7:0] OP_RDP        = 8'hAB;

  // ==========================================================
  // frame shape
  localparam int MODE_BITS_DEF  = 0;
  localparam int DUMMY_CLKS_DEF = 8;
  localparam logic [11:0] HDR_BITS = 12'h020;
  localparam logic [11:0] OP_BITS  = 12'h008;

  // lane modes: 1-1-1, 2-2-2, 4-4-4, anything else invalid
  localparam logic [1:0] LANE_1   = 2'h0;
  localparam logic [1:0] LANE_2   = 2'h1;
  localparam logic [1:0] LANE_4   = 2'h2;
  localparam logic [1:0] LANE_BAD = 2'h3;

  // ==========================================================
  // parameter table contents
  localparam logic [15:0] VMAX_WORD  = 16'h3600;
  localparam logic [15:0] VMIN_WORD  = 16'h2700;
  localparam logic [7:0]  BLANK      = 8'hFF;
  localparam logic [7:0]  SWRST_OP   = 8'hFF;
  localparam logic [7:0]  LOCK_OP    = 8'hFF;
  // capability word: hold, deep power-down, bit 14 set
  localparam logic [15:0] CAP_WORD   = {1'b0, 1'b1, 1'b0, 1'b0,
                                        SWRST_OP, 4'h6};
  // lock word: nonvolatile bit, unprotect default, top bits set
  localparam logic [15:0] LOCK_WORD  = {2'h3, 3'h0, 1'b1,
                                        LOCK_OP, 2'h2};

  // ==========================================================
  // controller register map and timing
  localparam logic [11:0] REG_CTRL   = 12'h000;
  localparam logic [11:0] REG_ADDR   = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_DATA   = 12'h00C;
  localparam int SYS_MHZ       = 10;
  localparam int SETTLE_US     = 100;
  localparam int SETTLE_CYC    = SETTLE_US * SYS_MHZ;
  localparam int SCLK_HALF_DEF = 4;

  // clock edges needed for a field of given bits
  function automatic logic [11:0] lane_edges(input logic [11:0] bits,
                                             input logic [1:0]  lane);
    return bits >> lane;
  endfunction

  // table lookup; unused locations read blank
  function automatic logic [7:0] param_byte(input logic [23:0] a);
    case (a)
      24'h000060: return VMAX_WORD[7:0];
      24'h000061: return VMAX_WORD[15:8];
      24'h000062: return VMIN_WORD[7:0];
      24'h000063: return VMIN_WORD[15:8];
      24'h000064: return CAP_WORD[7:0];
      24'h000065: return CAP_WORD[15:8];
      24'h000068: return LOCK_WORD[7:0];
      24'h000069: return LOCK_WORD[15:8];
      default:    return BLANK;
    endcase
  endfunction

endpackage
